// >>> rtl/pwmdu_top.sv
// top: register file and four pwm channels
// Overview of operation
// - duty update request loads a 16-bit duty 0..0x8000 into the chosen channel
// - zero duty holds the output at the inverse of polarity
// - full duty holds the output at the polarity level
// - duty in between modulates from period, duty and polarity
// - with duty defer set, new duty waits for the period end
// - duty changes never cut a pulse short or add a spike
// - combined request loads period and duty for one channel
// - with period defer set, new period waits for the period end
// - combined changes start a clean period, no malformed pulse
// - only variable-period channels take a new period
// - zero period ignores duty and drives the zero-duty level
// - period and duty become active together as a pair, except a duty-only update at count zero while a pair is pending
// - each channel has a class: fixed, fixed shifted or variable
module pwmdu_top (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // avalon-mm slave
  input wire logic [pwmdu_pkg::ADDR_W-1:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  output logic o_waitrequest,
  output logic [31:0] o_readdata,
  // pwm outputs
  output logic [pwmdu_pkg::NUM_CH-1:0] o_pwm
);

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] chclass;
    logic [pwmdu_pkg::CH_W-1:0] channel_index;
    logic [pwmdu_pkg::DUTY_W-1:0] duty_value;
    logic [pwmdu_pkg::PER_W-1:0] period_value;
    logic duty_update_request;
    logic period_duty_update_request;
  } pwmdu_regs_t;

  pwmdu_regs_t st;
  pwmdu_regs_t next_st;

  logic wr_stb;
  logic [pwmdu_pkg::ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [31:0] rd_mux;
  logic [pwmdu_pkg::NUM_CH-1:0] pending;
  logic [pwmdu_pkg::PER_W-1:0] act_per [pwmdu_pkg::NUM_CH];
  logic [pwmdu_pkg::DUTY_W-1:0] act_duty [pwmdu_pkg::NUM_CH];

  function automatic logic is_variable(
    input logic [31:0] cls,
    input int ch
  );
    logic [1:0] c;
    c = cls[2*ch +: 2];
    is_variable = (c == pwmdu_pkg::PWMDU_VARIABLE);
  endfunction : is_variable

  pwmdu_bus u_bus (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_address(i_address),
    .i_read(i_read),
    .i_write(i_write),
    .i_writedata(i_writedata),
    .i_rd_mux(rd_mux),
    .o_waitrequest(o_waitrequest),
    .o_readdata(o_readdata),
    .o_wr_stb(wr_stb),
    .o_wr_addr(wr_addr),
    .o_wr_data(wr_data)
  );

  // register writes; command bits are one-cycle pulses
  always_comb begin
    next_st = st;
    next_st.duty_update_request = 1'b0;
    next_st.period_duty_update_request = 1'b0;
    if (wr_stb) begin
      if (wr_addr == pwmdu_pkg::REG_CTRL) begin
        next_st.ctrl = wr_data & pwmdu_pkg::CTRL_MASK;
      end else if (wr_addr == pwmdu_pkg::REG_CH_SEL) begin
        next_st.channel_index = wr_data[pwmdu_pkg::CH_W-1:0];
      end else if (wr_addr == pwmdu_pkg::REG_DUTY) begin
        next_st.duty_value = wr_data[pwmdu_pkg::DUTY_W-1:0];
      end else if (wr_addr == pwmdu_pkg::REG_PERIOD) begin
        next_st.period_value = wr_data[pwmdu_pkg::PER_W-1:0];
      end else if (wr_addr == pwmdu_pkg::REG_CMD) begin
        next_st.duty_update_request = wr_data[pwmdu_pkg::CMD_DUTY_BIT];
        next_st.period_duty_update_request =
          wr_data[pwmdu_pkg::CMD_PD_BIT];
      end else if (wr_addr == pwmdu_pkg::REG_CLASS) begin
        next_st.chclass = wr_data & pwmdu_pkg::CLASS_MASK;
      end
    end
  end

  // read multiplexer; unmapped reads return zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (i_address == pwmdu_pkg::REG_CTRL) begin
      rd_mux = st.ctrl;
    end else if (i_address == pwmdu_pkg::REG_CH_SEL) begin
      rd_mux = {30'h0, st.channel_index};
    end else if (i_address == pwmdu_pkg::REG_DUTY) begin
      rd_mux = {16'h0000, st.duty_value};
    end else if (i_address == pwmdu_pkg::REG_PERIOD) begin
      rd_mux = {16'h0000, st.period_value};
    end else if (i_address == pwmdu_pkg::REG_STATUS) begin
      rd_mux = {24'h000000, o_pwm, pending};
    end else if (i_address == pwmdu_pkg::REG_CLASS) begin
      rd_mux = st.chclass;
    end else if (i_address == pwmdu_pkg::REG_ACT_PER) begin
      rd_mux = {16'h0000, act_per[st.channel_index]};
    end else if (i_address == pwmdu_pkg::REG_ACT_DUTY) begin
      rd_mux = {16'h0000, act_duty[st.channel_index]};
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st.ctrl <= pwmdu_pkg::CTRL_RESET;
      st.chclass <= pwmdu_pkg::CLASS_RESET;
      st.channel_index <= '0;
      st.duty_value <= pwmdu_pkg::DUTY_ZERO;
      st.period_value <= pwmdu_pkg::PER_ZERO;
      st.duty_update_request <= 1'b0;
      st.period_duty_update_request <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  genvar g;
  generate
    for (g = 0; g < pwmdu_pkg::NUM_CH; g++) begin : g_ch
      logic sel;
      assign sel = (st.channel_index == g);
      pwmdu_chan u_chan (
        .i_ref_clk(i_ref_clk),
        .i_reset_n(i_reset_n),
        .i_polarity(st.ctrl[pwmdu_pkg::CTRL_POL_LSB + g]),
        .i_duty_defer(st.ctrl[pwmdu_pkg::CTRL_DDEF_LSB + g]),
        .i_period_defer(st.ctrl[pwmdu_pkg::CTRL_PDEF_LSB + g]),
        .i_variable(is_variable(st.chclass, g)),
        .i_duty_req(sel && st.duty_update_request),
        .i_pd_req(sel && st.period_duty_update_request),
        .i_duty_value(st.duty_value),
        .i_period_value(st.period_value),
        .o_pwm(o_pwm[g]),
        .o_pending(pending[g]),
        .o_act_period(act_per[g]),
        .o_act_duty(act_duty[g])
      );
    end
  endgenerate

endmodule : pwmdu_top

// >>> inc/pwmdu_pkg.sv
// package: constants and types for the pwm duty/period update block
package pwmdu_pkg;

  localparam int NUM_CH = 4;
  localparam int CH_W = 2;
  localparam int DUTY_W = 16;
  localparam int PER_W = 16;
  localparam int ACT_W = 32;

  localparam logic [DUTY_W-1:0] DUTY_ZERO = 16'h0000;
  localparam logic [DUTY_W-1:0] DUTY_MAX = 16'h8000;
  localparam int DUTY_SHIFT = 15;

  localparam logic [PER_W-1:0] PER_ZERO = 16'h0000;
  localparam logic [PER_W-1:0] PER_ONE = 16'h0001;
  localparam logic [PER_W-1:0] PER_RESET = 16'h0064;
  localparam logic [DUTY_W-1:0] DUTY_RESET = 16'h4000;
  // on time of the reset period and duty pair
  localparam logic [PER_W-1:0] ON_RESET = 16'h0032;

  // avalon register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_CH_SEL = 8'h04;
  localparam logic [ADDR_W-1:0] REG_DUTY = 8'h08;
  localparam logic [ADDR_W-1:0] REG_PERIOD = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_CMD = 8'h10;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] REG_CLASS = 8'h18;
  localparam logic [ADDR_W-1:0] REG_ACT_PER = 8'h1c;
  localparam logic [ADDR_W-1:0] REG_ACT_DUTY = 8'h20;

  // ctrl: per channel polarity [3:0], duty defer [7:4], period defer [11:8]
  localparam int CTRL_POL_LSB = 0;
  localparam int CTRL_DDEF_LSB = 4;
  localparam int CTRL_PDEF_LSB = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_000f;
  localparam logic [31:0] CTRL_MASK = 32'h0000_0fff;
  localparam logic [31:0] CLASS_MASK = 32'h0000_00ff;
  // class: two bits per channel
  localparam logic [31:0] CLASS_RESET = 32'h0000_00aa;
  // cmd bits
  localparam int CMD_DUTY_BIT = 0;
  localparam int CMD_PD_BIT = 1;

  typedef enum logic [1:0] {
    PWMDU_FIXED = 2'h0,
    PWMDU_FIXED_SHIFT = 2'h1,
    PWMDU_VARIABLE = 2'h2
  } pwmdu_class_t;

  typedef enum logic [1:0] {
    PWMDU_IDLE,
    PWMDU_RD,
    PWMDU_WR
  } pwmdu_bus_st_t;

endpackage : pwmdu_pkg

// >>> rtl/pwmdu_chan.sv
// one pwm channel: counter, shadow and active settings, output
module pwmdu_chan (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // configuration
  input wire logic i_polarity,
  input wire logic i_duty_defer,
  input wire logic i_period_defer,
  input wire logic i_variable,
  // update request
  input wire logic i_duty_req,
  input wire logic i_pd_req,
  input wire logic [pwmdu_pkg::DUTY_W-1:0] i_duty_value,
  input wire logic [pwmdu_pkg::PER_W-1:0] i_period_value,
  // state
  output logic o_pwm,
  output logic o_pending,
  output logic [pwmdu_pkg::PER_W-1:0] o_act_period,
  output logic [pwmdu_pkg::DUTY_W-1:0] o_act_duty
);

  typedef struct packed {
    logic [pwmdu_pkg::PER_W-1:0] cnt;
    logic [pwmdu_pkg::PER_W-1:0] act_per;
    logic [pwmdu_pkg::DUTY_W-1:0] act_duty;
    logic [pwmdu_pkg::PER_W-1:0] act_on;
    logic [pwmdu_pkg::PER_W-1:0] pend_per;
    logic [pwmdu_pkg::DUTY_W-1:0] pend_duty;
    logic pend;
    logic pwm;
  } pwmdu_chan_st_t;

  pwmdu_chan_st_t st;
  pwmdu_chan_st_t next_st;

  function automatic logic [pwmdu_pkg::DUTY_W-1:0] sat_duty(
    input logic [pwmdu_pkg::DUTY_W-1:0] d
  );
    sat_duty = (d > pwmdu_pkg::DUTY_MAX) ? pwmdu_pkg::DUTY_MAX : d;
  endfunction : sat_duty

  function automatic logic [pwmdu_pkg::PER_W-1:0] on_time(
    input logic [pwmdu_pkg::PER_W-1:0] p,
    input logic [pwmdu_pkg::DUTY_W-1:0] d
  );
    logic [pwmdu_pkg::ACT_W-1:0] prod;
    prod = p * d;
    on_time = pwmdu_pkg::PER_W'(prod >> pwmdu_pkg::DUTY_SHIFT);
  endfunction : on_time

  logic last;
  logic [pwmdu_pkg::PER_W-1:0] req_per;
  logic [pwmdu_pkg::DUTY_W-1:0] req_duty;
  logic defer;

  always_comb begin
    next_st = st;
    last = (st.cnt >= st.act_per - pwmdu_pkg::PER_ONE) ||
           (st.act_per == pwmdu_pkg::PER_ZERO);
    req_duty = sat_duty(i_duty_value);
    req_per = i_variable ? i_period_value : st.act_per;
    defer = 1'b0;
    // counter wraps at the end of each period
    if (last) begin
      next_st.cnt = pwmdu_pkg::PER_ZERO;
    end else begin
      next_st.cnt = st.cnt + pwmdu_pkg::PER_ONE;
    end
    // pending pair applied together at the boundary
    if (st.pend && last) begin
      next_st.act_per = st.pend_per;
      next_st.act_duty = st.pend_duty;
      next_st.act_on = on_time(st.pend_per, st.pend_duty);
      next_st.pend = 1'b0;
      next_st.cnt = pwmdu_pkg::PER_ZERO;
    end
    if (i_pd_req) begin
      defer = i_period_defer || i_duty_defer;
      if (defer) begin
        next_st.pend_per = req_per;
        next_st.pend_duty = req_duty;
        next_st.pend = 1'b1;
      end else begin
        next_st.act_per = req_per;
        next_st.act_duty = req_duty;
        next_st.act_on = on_time(req_per, req_duty);
        next_st.cnt = pwmdu_pkg::PER_ZERO;
        next_st.pend = 1'b0;
      end
    end else if (i_duty_req) begin
      if (i_duty_defer) begin
        next_st.pend_per = st.pend ? st.pend_per : st.act_per;
        next_st.pend_duty = req_duty;
        next_st.pend = 1'b1;
      end else begin
        // new duty takes effect next period start, or at once while cnt is zero, no mid cycle spike
        next_st.pend_per = st.pend ? st.pend_per : st.act_per;
        next_st.pend_duty = req_duty;
        next_st.pend = 1'b1;
        if (st.cnt == pwmdu_pkg::PER_ZERO) begin
          next_st.act_duty = req_duty;
          next_st.act_on = on_time(st.act_per, req_duty);
          next_st.pend = st.pend;
        end
      end
    end
    // output level from the settings now active
    if (next_st.act_per == pwmdu_pkg::PER_ZERO) begin
      next_st.pwm = ~i_polarity;
    end else if (next_st.act_duty == pwmdu_pkg::DUTY_ZERO) begin
      next_st.pwm = ~i_polarity;
    end else if (next_st.act_duty >= pwmdu_pkg::DUTY_MAX) begin
      next_st.pwm = i_polarity;
    end else begin
      next_st.pwm = (next_st.cnt < next_st.act_on) ? i_polarity
                                                   : ~i_polarity;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st.cnt <= pwmdu_pkg::PER_ZERO;
      st.act_per <= pwmdu_pkg::PER_RESET;
      st.act_duty <= pwmdu_pkg::DUTY_RESET;
      st.act_on <= pwmdu_pkg::ON_RESET;
      st.pend_per <= pwmdu_pkg::PER_RESET;
      st.pend_duty <= pwmdu_pkg::DUTY_RESET;
      st.pend <= 1'b0;
      st.pwm <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign o_pwm = st.pwm;
  assign o_pending = st.pend;
  assign o_act_period = st.act_per;
  assign o_act_duty = st.act_duty;

endmodule : pwmdu_chan

// >>> rtl/pwmdu_bus.sv
// avalon-mm slave front end with fixed one wait state
module pwmdu_bus (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // avalon request
  input wire logic [pwmdu_pkg::ADDR_W-1:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [31:0] i_rd_mux,
  // avalon answer
  output logic o_waitrequest,
  output logic [31:0] o_readdata,
  // write strobe to register file
  output logic o_wr_stb,
  output logic [pwmdu_pkg::ADDR_W-1:0] o_wr_addr,
  output logic [31:0] o_wr_data
);

  typedef struct packed {
    pwmdu_pkg::pwmdu_bus_st_t fsm;
    logic wait_rq;
    logic [31:0] rdata;
    logic stb;
    logic [pwmdu_pkg::ADDR_W-1:0] waddr;
    logic [31:0] wdata;
  } pwmdu_bus_s_t;

  pwmdu_bus_s_t st;
  pwmdu_bus_s_t next_st;

  always_comb begin
    next_st = st;
    next_st.stb = 1'b0;
    next_st.wait_rq = 1'b1;
    case (st.fsm)
      pwmdu_pkg::PWMDU_IDLE: begin
        if (i_read) begin
          next_st.fsm = pwmdu_pkg::PWMDU_RD;
          next_st.rdata = i_rd_mux;
          next_st.wait_rq = 1'b0;
        end else if (i_write) begin
          next_st.fsm = pwmdu_pkg::PWMDU_WR;
          next_st.stb = 1'b1;
          next_st.waddr = i_address;
          next_st.wdata = i_writedata;
          next_st.wait_rq = 1'b0;
        end
      end
      default: begin
        next_st.fsm = pwmdu_pkg::PWMDU_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st <= '{fsm: pwmdu_pkg::PWMDU_IDLE, wait_rq: 1'b1, rdata: '0,
              stb: 1'b0, waddr: '0, wdata: '0};
    end else begin
      st <= next_st;
    end
  end

  assign o_waitrequest = st.wait_rq;
  assign o_readdata = st.rdata;
  assign o_wr_stb = st.stb;
  assign o_wr_addr = st.waddr;
  assign o_wr_data = st.wdata;

endmodule : pwmdu_bus

// >>> dv/pwmdu_assertions.sv
// checker: bus and output assertions for pwmdu_top
module pwmdu_assertions (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // avalon and outputs
  input wire logic [pwmdu_pkg::ADDR_W-1:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic o_waitrequest,
  input wire logic [31:0] o_readdata,
  input wire logic [pwmdu_pkg::NUM_CH-1:0] o_pwm
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  logic rd_done;
  assign rd_done = i_read && !o_waitrequest;
  req_answer_a: assert property ((i_read || i_write) && o_waitrequest
    |-> ##[1:2] !o_waitrequest) else $error("request not answered");
  no_req_a: assert property (!(i_read || i_write) |=> o_waitrequest)
    else $error("answer without request");
  one_wait_a: assert property (!o_waitrequest |=> o_waitrequest)
    else $error("waitrequest low too long");
  rd_hold_a: assert property (!i_read |=> $stable(o_readdata))
    else $error("readdata changed without read");
  unmapped_zero_a: assert property (rd_done
    && i_address > pwmdu_pkg::REG_ACT_DUTY |-> o_readdata == 32'h0)
    else $error("unmapped read not zero");
  status_pwm_a: assert property (rd_done
    && i_address == pwmdu_pkg::REG_STATUS
    |-> o_readdata[7:4] == $past(o_pwm)) else $error("status pwm wrong");
  act_sat_a: assert property (
    rd_done && i_address == pwmdu_pkg::REG_ACT_DUTY
    |-> o_readdata[15:0] <= pwmdu_pkg::DUTY_MAX) else $error("duty high");
  act_width_a: assert property (
    rd_done && (i_address == pwmdu_pkg::REG_ACT_PER
    || i_address == pwmdu_pkg::REG_ACT_DUTY)
    |-> o_readdata[31:16] == 16'h0) else $error("upper bits set");
endmodule : pwmdu_assertions

// >>> dv/pwmdu_host.sv
// host model: avalon master issuing duty and period updates
module pwmdu_host (
  // clock
  input wire logic i_ref_clk,
  // avalon master side
  output logic [pwmdu_pkg::ADDR_W-1:0] o_address,
  output logic o_read,
  output logic o_write,
  output logic [31:0] o_writedata,
  input wire logic i_waitrequest,
  input wire logic [31:0] i_readdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_address = 8'h00;
    o_read = 1'b0;
    o_write = 1'b0;
    o_writedata = 32'h0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    o_address <= a;
    o_writedata <= d;
    o_write <= 1'b1;
    do @(posedge i_ref_clk); while (i_waitrequest !== 1'b0);
    o_write <= 1'b0;
    o_address <= ~a;
    o_writedata <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_ref_clk);
    o_address <= a;
    o_read <= 1'b1;
    do @(posedge i_ref_clk); while (i_waitrequest !== 1'b0);
    d = i_readdata;
    o_read <= 1'b0;
    o_address <= ~a;
  endtask : rd
  // duty only or period and duty; duty written as given, not clamped
  task automatic upd(input logic [1:0] channel_index,
    input logic [15:0] period_value, input logic [15:0] duty_value,
    input logic pd);
    wr(pwmdu_pkg::REG_CH_SEL, {30'h0, channel_index});
    if (pd) wr(pwmdu_pkg::REG_PERIOD, {16'h0, period_value});
    wr(pwmdu_pkg::REG_DUTY, {16'h0, duty_value});
    wr(pwmdu_pkg::REG_CMD, pd ? 32'h2 : 32'h1);
  endtask : upd
endmodule : pwmdu_host

// >>> dv/tb_pwmdu_top.sv
// testbench for pwmdu_top
module tb_pwmdu_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_ref_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [7:0] i_address;
  logic i_read;
  logic i_write;
  logic o_waitrequest;
  logic [31:0] i_writedata;
  logic [31:0] o_readdata;
  logic [31:0] rdv;
  logic [3:0] o_pwm;
  logic [15:0] dt [4] = '{16'h0000, 16'h2000, 16'h8000, 16'h9000};
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;
  int on;
  always #20 i_ref_clk = ~i_ref_clk;
  pwmdu_top u_dut (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
    .i_address(i_address), .i_read(i_read), .i_write(i_write),
    .i_writedata(i_writedata), .o_waitrequest(o_waitrequest),
    .o_readdata(o_readdata), .o_pwm(o_pwm));
  pwmdu_host u_host (.i_ref_clk(i_ref_clk), .o_address(i_address),
    .o_read(i_read), .o_write(i_write), .o_writedata(i_writedata),
    .i_waitrequest(o_waitrequest), .i_readdata(o_readdata));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    u_host.rd(a, rdv);
    chk(rdv, exp);
  endtask : rchk
  task automatic hi_cnt(input int ch, input int n, input int exp);
    int c = 0;
    repeat (n) begin
      @(posedge i_ref_clk);
      if (o_pwm[ch] === 1'b1) c++;
    end
    chk(c, exp);
  endtask : hi_cnt
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (12) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    rchk(pwmdu_pkg::REG_CTRL, pwmdu_pkg::CTRL_RESET);
    rchk(pwmdu_pkg::REG_CLASS, pwmdu_pkg::CLASS_RESET);
    rchk(pwmdu_pkg::REG_ACT_PER, {16'h0, pwmdu_pkg::PER_RESET});
    rchk(pwmdu_pkg::REG_ACT_DUTY, {16'h0, pwmdu_pkg::DUTY_RESET});
    rchk(8'h40, 32'h0);
    $display("test reset done");
    for (int p = 1; p >= 0; p--) begin
      u_host.wr(pwmdu_pkg::REG_CTRL, 32'he | p);
      foreach (dt[i]) begin
        u_host.upd(2'h0, 16'h50, dt[i], 1'b1);
        repeat (6) @(posedge i_ref_clk);
        on = dt[i] >= pwmdu_pkg::DUTY_MAX ? 80 : (80 * dt[i]) >> 15;
        hi_cnt(0, 80, p ? on : 80 - on);
      end
    end
    rchk(pwmdu_pkg::REG_ACT_PER, 32'h50);
    rchk(pwmdu_pkg::REG_ACT_DUTY, 32'h8000);
    $display("test levels done");
    u_host.wr(pwmdu_pkg::REG_CTRL, 32'hf);
    u_host.wr(pwmdu_pkg::REG_CLASS, 32'ha2);
    u_host.upd(2'h1, 16'h28, 16'h6000, 1'b1);
    repeat (4) @(posedge i_ref_clk);
    rchk(pwmdu_pkg::REG_ACT_PER, 32'h64);
    rchk(pwmdu_pkg::REG_ACT_DUTY, 32'h6000);
    u_host.upd(2'h0, 16'h0, 16'h8000, 1'b1);
    repeat (6) @(posedge i_ref_clk);
    hi_cnt(0, 50, 0);
    $display("test class and zero period done");
    for (int k = 0; k < 2; k++) begin
      u_host.wr(pwmdu_pkg::REG_CTRL, 32'hf);
      u_host.upd(2'h2, 16'h64, 16'h4000, 1'b1);
      u_host.wr(pwmdu_pkg::REG_CTRL, k ? 32'h40f : 32'h4f);
      u_host.upd(2'h2, 16'h3c, 16'h2000, k[0]);
      u_host.rd(pwmdu_pkg::REG_STATUS, rdv);
      chk(rdv[2], 1'b1);
      rchk(pwmdu_pkg::REG_ACT_PER, 32'h64);
      rchk(pwmdu_pkg::REG_ACT_DUTY, 32'h4000);
      repeat (100) @(posedge i_ref_clk);
      u_host.rd(pwmdu_pkg::REG_STATUS, rdv);
      chk(rdv[2], 1'b0);
      rchk(pwmdu_pkg::REG_ACT_PER, k ? 32'h3c : 32'h64);
      rchk(pwmdu_pkg::REG_ACT_DUTY, 32'h2000);
    end
    hi_cnt(2, 60, 15);
    // duty only, not deferred: takes effect at the next wrap
    u_host.upd(2'h2, 16'h0, 16'h4000, 1'b0);
    repeat (70) @(posedge i_ref_clk);
    rchk(pwmdu_pkg::REG_ACT_DUTY, 32'h4000);
    rchk(pwmdu_pkg::REG_ACT_PER, 32'h3c);
    hi_cnt(2, 60, 30);
    $display("test deferred updates done");
    tally_and_finish();
  end
endmodule : tb_pwmdu_top
bind pwmdu_top pwmdu_assertions u_chk (.i_ref_clk(i_ref_clk),
  .i_reset_n(i_reset_n), .i_address(i_address), .i_read(i_read),
  .i_write(i_write), .i_writedata(i_writedata),
  .o_waitrequest(o_waitrequest), .o_readdata(o_readdata), .o_pwm(o_pwm));
